// ---- core/otflr_top.sv ----
// Overtemperature fault threshold and response register bank with fault handling
// Behaviour
// - Threshold bits 15:11 read a fixed exponent 00010b, four degrees per step.
// - Threshold bits 10:6 are reserved and always read zero.
// - Threshold bits 5:0 hold writable mantissa, defaulting from NVM to 135 C.
// - Written mantissa reads back exactly; applied threshold is nearest supported value.
// - NVM restore loads a fixed representative mantissa per supported setting.
// - Writes changing bits 15:6 are NACKed, dropped, set cml and ivd.
// - Mantissa bins: <30 115, 30 120, 31 125, 32-33 130, up to 37+ 150.
// - Fault detection compares die temperature telemetry against selected threshold digitally.
// - Action byte is command 50h, byte write and read, NVM backed.
// - On fault act per retry field, set temperature fault flag, assert alert.
// - Action bit 7 reads one; the output shuts down on fault.
// - Action bit 6 is unused and reads zero.
// - Retry 000b latches off until power cycle or enable toggle.
// - Retry 111b restarts after 52 ms, unlimited, until off or other fault.
// - Retry values other than 000b or 111b are rejected as invalid data.
// - Only bit 5 is kept in NVM; the field is rebuilt from it.
// - Bits 2:0 mirror the retry field as the read-only retry delay.
`timescale 1ns/1ps
module otflr_top
   import otflr_pkg::*;
#(
   parameter int RESTART_CYC = OTFLR_RESTART_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Host command port
   input wire otflr_req_t req,
   output otflr_rsp_t rsp,
   // NVM restore image
   input wire logic nvm_load,
   input wire logic [5:0] nvm_mant,
   input wire logic nvm_retry_bit,
   // Power stage and telemetry
   input wire logic [7:0] die_temp,
   input wire logic temp_valid,
   input wire logic enable_in,
   input wire logic other_fault,
   output logic output_enable,
   // Status toward host
   input wire logic status_clear,
   output logic overtemp_fault_flag,
   output logic cml_flag,
   output logic ivd_flag,
   output logic smb_alert_n
);
   localparam int CW = $clog2(RESTART_CYC + 1);

   logic [5:0] mant, next_mant;
   logic retry_bit, next_retry_bit;
   logic flag, next_flag, cml, next_cml, ivd, next_ivd;
   otflr_rsp_t next_rsp;
   otflr_state_t state, next_state;
   logic [CW-1:0] cnt, next_cnt;
   logic en_d, next_en_d;
   logic [7:0] fault_temp_setting;
   logic [15:0] thr_word;
   logic [7:0] act_byte;
   logic [2:0] retry_sel;
   logic fault_hit;
   logic bad_thr, bad_act;

   // Bin the stored mantissa to the supported threshold
   always_comb begin
      if (mant < OTFLR_BIN_120) fault_temp_setting = OTFLR_T115;
      else if (mant < OTFLR_BIN_125) fault_temp_setting = OTFLR_T120;
      else if (mant < OTFLR_BIN_130) fault_temp_setting = OTFLR_T125;
      else if (mant < OTFLR_BIN_135) fault_temp_setting = OTFLR_T130;
      else if (mant < OTFLR_BIN_140) fault_temp_setting = OTFLR_T135;
      else if (mant < OTFLR_BIN_145) fault_temp_setting = OTFLR_T140;
      else if (mant < OTFLR_BIN_150) fault_temp_setting = OTFLR_T145;
      else fault_temp_setting = OTFLR_T150;
   end

   // Register images; fixed fields never come from storage
   assign thr_word = {OTFLR_EXPONENT, OTFLR_RSVD_ZERO, mant};
   assign retry_sel = {3{retry_bit}};
   assign act_byte = {1'b1, 1'b0, retry_sel, retry_sel};
   assign fault_hit = temp_valid && (die_temp >= fault_temp_setting);
   assign bad_thr = req.data[15:6] != thr_word[15:6];
   assign bad_act = !req.data[OTFLR_ACT_SHUT_BIT] || req.data[OTFLR_ACT_UNUSED_BIT]
      || (req.data[5:3] != OTFLR_RETRY_LATCH && req.data[5:3] != OTFLR_RETRY_AUTO)
      || (req.data[2:0] != req.data[5:3]);

   // NVM restore, host access and status flags
   always_comb begin
      next_mant = mant;
      next_retry_bit = retry_bit;
      next_cml = cml;
      next_ivd = ivd;
      next_flag = flag;
      next_rsp = '0;
      if (status_clear) begin
         next_cml = 1'b0;
         next_ivd = 1'b0;
         next_flag = 1'b0;
      end
      if (nvm_load) begin
         // Representative mantissa per bin, arbitrary codes collapse
         case (fault_temp_setting)
            OTFLR_T115: next_mant = OTFLR_REST_115;
            OTFLR_T120: next_mant = OTFLR_BIN_120;
            OTFLR_T125: next_mant = OTFLR_BIN_125;
            OTFLR_T130: next_mant = OTFLR_BIN_130;
            OTFLR_T135: next_mant = OTFLR_BIN_135;
            OTFLR_T140: next_mant = OTFLR_BIN_140;
            OTFLR_T145: next_mant = OTFLR_BIN_145;
            default: next_mant = OTFLR_BIN_150;
         endcase
         next_mant = nvm_bin(nvm_mant);
         next_retry_bit = nvm_retry_bit;
      end else if (req.wr && req.code == OTFLR_CMD_THRESHOLD) begin
         if (bad_thr) begin
            next_rsp.nack = 1'b1;
            next_cml = 1'b1;
            next_ivd = 1'b1;
         end else begin
            next_rsp.ack = 1'b1;
            next_mant = req.data[5:0];
         end
      end else if (req.wr && req.code == OTFLR_CMD_ACTION) begin
         if (bad_act) begin
            next_rsp.nack = 1'b1;
            next_cml = 1'b1;
            next_ivd = 1'b1;
         end else begin
            next_rsp.ack = 1'b1;
            next_retry_bit = req.data[OTFLR_ACT_NVM_BIT];
         end
      end else if (req.rd && req.code == OTFLR_CMD_THRESHOLD) begin
         next_rsp.ack = 1'b1;
         next_rsp.data = thr_word;
      end else if (req.rd && req.code == OTFLR_CMD_ACTION) begin
         next_rsp.ack = 1'b1;
         next_rsp.data = {8'h00, act_byte};
      end else if (req.rd || req.wr) begin
         next_rsp.nack = 1'b1;
      end
      // Set wins over a clear in the same cycle
      if (fault_hit) next_flag = 1'b1;
   end

   // Restore a fixed mantissa for the bin of an NVM image
   function automatic logic [5:0] nvm_bin(input logic [5:0] m);
      if (m < OTFLR_BIN_120) nvm_bin = OTFLR_REST_115;
      else if (m < OTFLR_BIN_125) nvm_bin = OTFLR_BIN_120;
      else if (m < OTFLR_BIN_130) nvm_bin = OTFLR_BIN_125;
      else if (m < OTFLR_BIN_135) nvm_bin = OTFLR_BIN_130;
      else if (m < OTFLR_BIN_140) nvm_bin = OTFLR_BIN_135;
      else if (m < OTFLR_BIN_145) nvm_bin = OTFLR_BIN_140;
      else if (m < OTFLR_BIN_150) nvm_bin = OTFLR_BIN_145;
      else nvm_bin = OTFLR_BIN_150;
   endfunction : nvm_bin

   // Register stage for configuration and status
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         mant <= OTFLR_MANT_DEFAULT;
         retry_bit <= 1'b0;
         cml <= 1'b0;
         ivd <= 1'b0;
         flag <= 1'b0;
         rsp <= '0;
      end else begin
         mant <= next_mant;
         retry_bit <= next_retry_bit;
         cml <= next_cml;
         ivd <= next_ivd;
         flag <= next_flag;
         rsp <= next_rsp;
      end
   end

   // Shutdown and restart sequencing
   // RUN passes power, LATCHED holds it off until a fresh enable edge,
   // WAIT times the restart delay. A hot die seen during WAIT is ignored,
   // since the output is already off; the next check happens back in RUN.
   // Limitation: the restart delay is counted in core clocks, so a slower
   // core clock needs a matching RESTART_CYC override.
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_en_d = enable_in;
      case (state)
         OTFLR_RUN: begin
            if (fault_hit) begin
               next_cnt = '0;
               next_state = retry_bit ? OTFLR_WAIT : OTFLR_LATCHED;
            end
         end
         OTFLR_LATCHED: begin
            // Only an enable rising edge re-arms the output
            if (enable_in && !en_d) next_state = OTFLR_RUN;
         end
         OTFLR_WAIT: begin
            if (!enable_in || other_fault) begin
               next_cnt = '0;
               next_state = OTFLR_LATCHED;
            end else if (cnt == CW'(RESTART_CYC - 1)) begin
               next_cnt = '0;
               next_state = OTFLR_RUN;
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
         default: next_state = OTFLR_LATCHED;
      endcase
   end

   // Register stage for the sequencer
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state <= OTFLR_RUN;
         cnt <= '0;
         en_d <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         en_d <= next_en_d;
      end
   end

   // Outputs
   assign output_enable = (state == OTFLR_RUN) && enable_in && !fault_hit;
   assign overtemp_fault_flag = flag;
   assign cml_flag = cml;
   assign ivd_flag = ivd;
   assign smb_alert_n = !(flag || cml);

   // Checks
   AST_RO_FIELDS: assert property (@(posedge core_clk) disable iff (!nrst)
      thr_word[15:6] == {OTFLR_EXPONENT, OTFLR_RSVD_ZERO}) else $error("ro bits");
   AST_ACT_FIXED: assert property (@(posedge core_clk) disable iff (!nrst)
      act_byte[7:6] == 2'b10 && act_byte[2:0] == act_byte[5:3]) else $error("act");
   AST_BAD_NACK: assert property (@(posedge core_clk) disable iff (!nrst)
      req.wr && req.code == OTFLR_CMD_THRESHOLD && bad_thr && !nvm_load
      |=> rsp.nack && ivd && cml && mant == $past(mant)) else $error("nack");
   AST_WR_BACK: assert property (@(posedge core_clk) disable iff (!nrst)
      req.wr && req.code == OTFLR_CMD_THRESHOLD && !bad_thr && !nvm_load
      |=> mant == $past(req.data[5:0])) else $error("readback");
   AST_RETRY_BAD: assert property (@(posedge core_clk) disable iff (!nrst)
      req.wr && req.code == OTFLR_CMD_ACTION && bad_act && !nvm_load
      |=> rsp.nack && retry_bit == $past(retry_bit)) else $error("retry");
   AST_FLAG_SET: assert property (@(posedge core_clk) disable iff (!nrst)
      fault_hit |=> flag && !smb_alert_n) else $error("flag");
   AST_SHUT: assert property (@(posedge core_clk) disable iff (!nrst)
      fault_hit |-> !output_enable) else $error("shutdown");
   AST_LATCH: assert property (@(posedge core_clk) disable iff (!nrst)
      state == OTFLR_RUN && fault_hit && !retry_bit
      |=> state == OTFLR_LATCHED) else $error("latch");
   AST_BIN_150: assert property (@(posedge core_clk) disable iff (!nrst)
      mant >= OTFLR_BIN_150 |-> fault_temp_setting == OTFLR_T150) else $error("bin");
   AST_CNT_CLR: assert property (@(posedge core_clk) disable iff (!nrst)
      state == OTFLR_WAIT && other_fault |=> cnt == '0) else $error("cnt");

   // Host answers: one kind per answer, reads return the live images
   AST_ONE_ANSWER: assert property (@(posedge core_clk) disable iff (!nrst)
      !(rsp.ack && rsp.nack)) else $error("ack and nack");
   AST_THR_RD: assert property (@(posedge core_clk) disable iff (!nrst)
      req.rd && !req.wr && req.code == OTFLR_CMD_THRESHOLD && !nvm_load
      |=> rsp.ack && rsp.data == $past(thr_word)) else $error("thr read");
   AST_ACT_RD: assert property (@(posedge core_clk) disable iff (!nrst)
      req.rd && !req.wr && req.code == OTFLR_CMD_ACTION && !nvm_load
      |=> rsp.ack && rsp.data == {8'h00, $past(act_byte)}) else $error("act read");
   AST_ACT_STORE: assert property (@(posedge core_clk) disable iff (!nrst)
      req.wr && req.code == OTFLR_CMD_ACTION && !bad_act && !nvm_load
      |=> retry_bit == $past(req.data[5])) else $error("act store");

   // Restore image lands on a representative code
   AST_NVM_REST: assert property (@(posedge core_clk) disable iff (!nrst)
      nvm_load |=> mant == nvm_bin($past(nvm_mant))) else $error("restore");

   // Telemetry without a valid result never trips the comparator
   AST_VALID_GATE: assert property (@(posedge core_clk) disable iff (!nrst)
      !temp_valid |-> !fault_hit) else $error("valid gate");

   // Sequencer: auto restart path and latch hold
   AST_AUTO_WAIT: assert property (@(posedge core_clk) disable iff (!nrst)
      state == OTFLR_RUN && fault_hit && retry_bit
      |=> state == OTFLR_WAIT) else $error("auto wait");
   AST_RESTART: assert property (@(posedge core_clk) disable iff (!nrst)
      state == OTFLR_WAIT && cnt == CW'(RESTART_CYC - 1) && enable_in && !other_fault
      |=> state == OTFLR_RUN) else $error("restart");
   AST_OE_WAIT: assert property (@(posedge core_clk) disable iff (!nrst)
      state != OTFLR_RUN |-> !output_enable) else $error("oe off");
   AST_LATCH_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
      state == OTFLR_LATCHED && !(enable_in && !en_d)
      |=> state == OTFLR_LATCHED) else $error("latch hold");

   // Main scenarios worth seeing at least once
   COV_LATCH: cover property (@(posedge core_clk) state == OTFLR_LATCHED);
   COV_RETRY: cover property (@(posedge core_clk)
      state == OTFLR_WAIT ##1 state == OTFLR_RUN);
   COV_NACK: cover property (@(posedge core_clk) rsp.nack);
   COV_AUTO_CFG: cover property (@(posedge core_clk) retry_bit && state == OTFLR_RUN);
   COV_ABORT: cover property (@(posedge core_clk) state == OTFLR_WAIT && other_fault);
endmodule : otflr_top

// ---- core/otflr_pkg.sv ----
// Package: overtemperature fault threshold and action register constants and types
package otflr_pkg;
   // Command codes
   localparam logic [7:0] OTFLR_CMD_THRESHOLD = 8'h4F;
   localparam logic [7:0] OTFLR_CMD_ACTION = 8'h50;
   // Threshold word layout
   localparam logic [4:0] OTFLR_EXPONENT = 5'h02;
   localparam logic [4:0] OTFLR_RSVD_ZERO = 5'h00;
   localparam logic [5:0] OTFLR_MANT_DEFAULT = 6'h22;
   // Binning edges of the mantissa
   localparam logic [5:0] OTFLR_BIN_120 = 6'h1E;
   localparam logic [5:0] OTFLR_BIN_125 = 6'h1F;
   localparam logic [5:0] OTFLR_BIN_130 = 6'h20;
   localparam logic [5:0] OTFLR_BIN_135 = 6'h22;
   localparam logic [5:0] OTFLR_BIN_140 = 6'h23;
   localparam logic [5:0] OTFLR_BIN_145 = 6'h24;
   localparam logic [5:0] OTFLR_BIN_150 = 6'h25;
   // Representative restore mantissa for 115 C; the other settings reuse the bin edges
   localparam logic [5:0] OTFLR_REST_115 = 6'h1D;
   // Thresholds in degrees Celsius
   localparam logic [7:0] OTFLR_T115 = 8'h73;
   localparam logic [7:0] OTFLR_T120 = 8'h78;
   localparam logic [7:0] OTFLR_T125 = 8'h7D;
   localparam logic [7:0] OTFLR_T130 = 8'h82;
   localparam logic [7:0] OTFLR_T135 = 8'h87;
   localparam logic [7:0] OTFLR_T140 = 8'h8C;
   localparam logic [7:0] OTFLR_T145 = 8'h91;
   localparam logic [7:0] OTFLR_T150 = 8'h96;
   // Action byte layout
   localparam int OTFLR_ACT_SHUT_BIT = 7;
   localparam int OTFLR_ACT_UNUSED_BIT = 6;
   localparam int OTFLR_ACT_NVM_BIT = 5;
   localparam logic [2:0] OTFLR_RETRY_LATCH = 3'h0;
   localparam logic [2:0] OTFLR_RETRY_AUTO = 3'h7;
   // Restart delay
   localparam int OTFLR_RESTART_MS = 52;
   localparam int OTFLR_CLK_MHZ = 100;
   localparam int OTFLR_RESTART_CYC = OTFLR_RESTART_MS * 1000 * OTFLR_CLK_MHZ;

   // Host command request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] code;
      logic [15:0] data;
   } otflr_req_t;

   // Device reply
   typedef struct packed {
      logic ack;
      logic nack;
      logic [15:0] data;
   } otflr_rsp_t;

   typedef enum logic [1:0] {OTFLR_RUN, OTFLR_LATCHED, OTFLR_WAIT} otflr_state_t;
endpackage : otflr_pkg

// ---- tb/otflr_host.sv ----
// Host model: issues byte and word commands to the threshold and action bank
`timescale 1ns/1ps
module otflr_host
   import otflr_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Command port
   output otflr_req_t req,
   input wire otflr_rsp_t rsp
);
   initial req = '0;

   // One command, held to the taking edge; released code and data lines are inverted so stale data fails
   task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
         output logic nk, output logic [15:0] rdata);
      req.wr = w;
      req.rd = ~w;
      req.code = c;
      req.data = (c == OTFLR_CMD_ACTION) ? {8'h00, d[7:0]} : d;
      @(posedge core_clk);
      #1;
      req.wr = 1'b0;
      req.rd = 1'b0;
      req.code = ~c;
      req.data = ~req.data;
      // Answer within a few cycles, else unknown so the check fails
      for (int i = 0; i < 3; i++) begin
         if ((rsp.ack | rsp.nack) === 1'b1) break;
         @(posedge core_clk);
         #1;
      end
      nk = (rsp.ack === 1'b1) ? 1'b0 : ((rsp.nack === 1'b1) ? 1'b1 : 1'bx);
      rdata = rsp.data;
   endtask : cmd
endmodule : otflr_host

// ---- tb/tb.sv ----
// Self-checking bench for the overtemperature threshold and action bank
`timescale 1ns/1ps
module tb;
   import otflr_pkg::*;
   localparam int RCYC = 20;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   otflr_req_t req;
   otflr_rsp_t rsp;
   logic nvm_load = 1'b0;
   logic [5:0] nvm_mant = 6'h00;
   logic nvm_retry_bit = 1'b0;
   logic [7:0] die_temp = 8'h00;
   logic temp_valid = 1'b1;
   logic enable_in = 1'b1;
   logic other_fault = 1'b0;
   logic status_clear = 1'b0;
   logic output_enable, overtemp_fault_flag, cml_flag, ivd_flag, smb_alert_n;
   int bad_count = 0;
   int num_checks = 0;
   logic nk;
   logic [15:0] rd;
   // Mantissa beside the threshold it must apply
   logic [13:0] rows [10] = '{{6'h00, OTFLR_T115}, {6'h1E, OTFLR_T120}, {6'h1F, OTFLR_T125},
      {6'h20, OTFLR_T130}, {6'h21, OTFLR_T130}, {6'h22, OTFLR_T135}, {6'h23, OTFLR_T140},
      {6'h24, OTFLR_T145}, {6'h25, OTFLR_T150}, {6'h3F, OTFLR_T150}};
   // Writes that must be refused: code then data
   logic [23:0] bad [6] = '{24'h4F1822, 24'h4F0022, 24'h4F1062, 24'h500000, 24'h5000F8,
      24'h5000B8};

   always #5 core_clk = ~core_clk;

   otflr_top #(.RESTART_CYC(RCYC)) dut_u (.core_clk(core_clk), .nrst(nrst), .req(req),
      .rsp(rsp), .nvm_load(nvm_load), .nvm_mant(nvm_mant), .nvm_retry_bit(nvm_retry_bit),
      .die_temp(die_temp), .temp_valid(temp_valid), .enable_in(enable_in),
      .other_fault(other_fault), .output_enable(output_enable), .status_clear(status_clear),
      .overtemp_fault_flag(overtemp_fault_flag), .cml_flag(cml_flag), .ivd_flag(ivd_flag),
      .smb_alert_n(smb_alert_n));
   otflr_host host_u (.core_clk(core_clk), .req(req), .rsp(rsp));

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Command through the host, answer kind compared
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, input logic e);
      host_u.cmd(w, c, d, nk, rd);
      chk("nack", {15'h0, e}, {15'h0, nk});
   endtask : xfer

   // Clear status and toggle enable so a latched output may restart
   task automatic recover;
      die_temp = 8'h00;
      enable_in = 1'b0;
      status_clear = 1'b1;
      tick(1);
      status_clear = 1'b0;
      enable_in = 1'b1;
      tick(3);
   endtask : recover

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim

   // Watchdog, well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      end_sim();
   end

   initial begin
      tick(20);
      nrst = 1'b1;
      // Bin table: each mantissa trips exactly at its threshold
      for (int i = 0; i < 10; i++) begin
         xfer(1'b1, OTFLR_CMD_THRESHOLD, {10'h040, rows[i][13:8]}, 1'b0);
         xfer(1'b0, OTFLR_CMD_THRESHOLD, 16'h0000, 1'b0);
         chk("thr rd", {OTFLR_EXPONENT, OTFLR_RSVD_ZERO, rows[i][13:8]}, rd);
         die_temp = rows[i][7:0] - 8'h01;
         tick(2);
         chk("oe below", 16'h1, {15'h0, output_enable});
         die_temp = rows[i][7:0];
         #1;
         chk("oe at", 16'h0, {15'h0, output_enable});
         tick(1);
         chk("flag alert", 16'h2, {14'h0, overtemp_fault_flag, smb_alert_n});
         die_temp = 8'h00;
         tick(RCYC + 5);
         chk("latched", 16'h0, {15'h0, output_enable});
         recover();
         chk("restart", 16'h1, {15'h0, output_enable});
      end
      $display("test bins done");
      // Mid-run reset restores defaults
      nrst = 1'b0;
      tick(3);
      nrst = 1'b1;
      xfer(1'b0, OTFLR_CMD_THRESHOLD, 16'h0000, 1'b0);
      chk("thr rst", 16'h1022, rd);
      xfer(1'b0, OTFLR_CMD_ACTION, 16'h0000, 1'b0);
      chk("act rst", 16'h0080, rd);
      chk("flags rst", 16'h1, {12'h0, overtemp_fault_flag, cml_flag, ivd_flag, smb_alert_n});
      $display("test reset done");
      // Refused writes leave contents alone and raise the fault bits
      for (int i = 0; i < 6; i++) begin
         xfer(1'b1, bad[i][23:16], bad[i][15:0], 1'b1);
         chk("cml ivd", 16'h6, {13'h0, cml_flag, ivd_flag, smb_alert_n});
      end
      xfer(1'b0, OTFLR_CMD_THRESHOLD, 16'h0000, 1'b0);
      chk("thr kept", 16'h1022, rd);
      xfer(1'b0, OTFLR_CMD_ACTION, 16'h0000, 1'b0);
      chk("act kept", 16'h0080, rd);
      recover();
      chk("cleared", 16'h1, {13'h0, cml_flag, ivd_flag, smb_alert_n});
      $display("test refuse done");
      // Auto restart after the delay, then a second fault aborts the wait
      xfer(1'b1, OTFLR_CMD_ACTION, 16'h00BF, 1'b0);
      xfer(1'b0, OTFLR_CMD_ACTION, 16'h0000, 1'b0);
      chk("act auto", 16'h00BF, rd);
      die_temp = 8'hFF;
      tick(1);
      die_temp = 8'h00;
      tick(RCYC - 5);
      chk("wait", 16'h0, {15'h0, output_enable});
      tick(10);
      chk("auto on", 16'h1, {15'h0, output_enable});
      die_temp = 8'hFF;
      tick(1);
      die_temp = 8'h00;
      tick(4);
      other_fault = 1'b1;
      tick(1);
      other_fault = 1'b0;
      tick(RCYC + 5);
      chk("abort", 16'h0, {15'h0, output_enable});
      recover();
      $display("test retry done");
      // Restore image: representative mantissa and rebuilt retry field
      nvm_mant = 6'h21;
      nvm_retry_bit = 1'b0;
      nvm_load = 1'b1;
      tick(1);
      nvm_load = 1'b0;
      xfer(1'b0, OTFLR_CMD_THRESHOLD, 16'h0000, 1'b0);
      chk("thr nvm", 16'h1020, rd);
      xfer(1'b0, OTFLR_CMD_ACTION, 16'h0000, 1'b0);
      chk("act nvm", 16'h0080, rd);
      $display("test restore done");
      // Hot reading without a valid result must leave power on
      temp_valid = 1'b0;
      die_temp = 8'hFF;
      tick(2);
      chk("no valid", 16'h1, {15'h0, output_enable});
      chk("no valid flag", 16'h0, {15'h0, overtemp_fault_flag});
      temp_valid = 1'b1;
      die_temp = 8'h00;
      tick(1);
      $display("test valid done");
      end_sim();
   end
endmodule : tb
